// File: verilog/sooc_params.svh
// Constants of the supply on/off and margin command block.
// Assumes a PMBus engine outside that frames transactions and holds the current page.
`ifndef SOOC_PARAMS_SVH
`define SOOC_PARAMS_SVH

`define SOOC_NCH           12
`define SOOC_CODE_OPER     8'h01
`define SOOC_CODE_CFG      8'h02
`define SOOC_PAGE_ALL      8'hFF
`define SOOC_PAGE_LAST     8'h0B
`define SOOC_OP_OFF        8'h00
`define SOOC_OP_SOFT       8'h40
`define SOOC_OP_ON         8'h80
`define SOOC_OP_LOW_IGN    8'h94
`define SOOC_OP_LOW_ACT    8'h98
`define SOOC_OP_HIGH_IGN   8'hA4
`define SOOC_OP_HIGH_ACT   8'hA8
`define SOOC_OP_STD_MASK   8'hFC
`define SOOC_NIB_BOTH      4'h0
`define SOOC_NIB_GRP_A     4'h1
`define SOOC_NIB_GRP_B     4'h2
`define SOOC_OP_ON_BIT     7
`define SOOC_CFG_WMASK     8'h3F
`define SOOC_CFG_RST       8'h1E
`define SOOC_OP_RST        8'h00
`define SOOC_RD_ZERO       8'h00

`endif

// File: verilog/sooc_pkg.sv
// Types of the supply on/off and margin command block.
// Assumes sooc_params.svh supplies the numeric constants.
package sooc_pkg;

  // layout of the source configuration byte, bit 7 first
  typedef struct packed {
    logic [1:0] rsvd;
    logic       or_mode;
    logic       use_src;
    logic       cmd_en;
    logic       pin_en;
    logic       pin_pol;
    logic       pin_imm;
  } sooc_cfg_t;

  typedef enum logic [2:0] {
    SOOC_MRG_OFF,
    SOOC_MRG_LOW_IGN,
    SOOC_MRG_LOW_ACT,
    SOOC_MRG_HIGH_IGN,
    SOOC_MRG_HIGH_ACT
  } sooc_margin_t;

endpackage : sooc_pkg

// File: verilog/sooc_top.sv
// Supply on/off and margin command decoder for twelve sequenced supplies.
// Assumes a PMBus engine presents each written command byte for one cycle,
// with the page already selected, and that fault detection and sequencing live outside.
`timescale 1ns/1ps
`include "sooc_params.svh"

module sooc_top (
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  input  wire logic                  CMD_WR,
  input  wire logic                  CMD_RD,
  input  wire logic [7:0]            CMD_CODE,
  input  wire logic [7:0]            CMD_DATA,
  input  wire logic [7:0]            CMD_PAGE,
  output logic      [7:0]            RD_DATA,
  output logic                       RD_VALID,
  output logic                       CML_FAULT,
  input  wire logic                  SUPPLY_CTRL_PIN_A,
  input  wire logic                  SUPPLY_CTRL_PIN_B,
  input  wire logic                  BIAS_OK,
  input  wire logic [`SOOC_NCH-1:0]  CH_ENABLED,
  input  wire logic [`SOOC_NCH-1:0]  CH_IN_GROUP_B,
  input  wire logic [`SOOC_NCH-1:0]  PG_OK,
  input  wire logic [`SOOC_NCH-1:0]  FAULT_IN,
  output logic      [`SOOC_NCH-1:0]  SUPPLY_ON,
  output logic      [`SOOC_NCH-1:0]  OFF_IMMEDIATE,
  output logic      [`SOOC_NCH-1:0]  MARGIN_HIGH,
  output logic      [`SOOC_NCH-1:0]  MARGIN_LOW,
  output logic      [`SOOC_NCH-1:0]  FAULT_OUT
);

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic [7:0]         cfg_reg;
  sooc_pkg::sooc_cfg_t cfg;
  wire                cfg_wr = CMD_WR && (CMD_CODE == `SOOC_CODE_CFG);

  // one setting serves both control pins alike
  assign cfg = sooc_pkg::sooc_cfg_t'(cfg_reg & `SOOC_CFG_WMASK);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cfg_reg <= `SOOC_CFG_RST;
    end else if (cfg_wr) begin
      cfg_reg <= CMD_DATA & `SOOC_CFG_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // command byte decode
  // ----------------------------------------------------------------
  wire       op_wr     = CMD_WR && (CMD_CODE == `SOOC_CODE_OPER);
  wire       page_all  = (CMD_PAGE == `SOOC_PAGE_ALL);
  wire       page_one  = (CMD_PAGE <= `SOOC_PAGE_LAST);
  wire [3:0] op_nib    = CMD_DATA[3:0];
  // group codes fold onto the standard code by clearing the two low bits
  wire [7:0] op_std    = CMD_DATA & `SOOC_OP_STD_MASK;
  wire       std_off   = (CMD_DATA == `SOOC_OP_OFF);
  wire       std_soft  = (CMD_DATA == `SOOC_OP_SOFT);
  wire       std_on    = (CMD_DATA == `SOOC_OP_ON);
  wire       std_mrg   = (CMD_DATA == `SOOC_OP_LOW_IGN) || (CMD_DATA == `SOOC_OP_LOW_ACT) ||
                         (CMD_DATA == `SOOC_OP_HIGH_IGN) || (CMD_DATA == `SOOC_OP_HIGH_ACT);
  wire       is_std    = std_off || std_soft || std_on || std_mrg;
  wire       grp_nib   = (op_nib == `SOOC_NIB_GRP_A) || (op_nib == `SOOC_NIB_GRP_B);
  wire       grp_base  = (op_std == `SOOC_OP_OFF) || (op_std == `SOOC_OP_SOFT) || (op_std == `SOOC_OP_ON);
  // group codes exist only at page 255 and only while the command source is enabled
  wire       is_grp    = grp_base && grp_nib && page_all && cfg.cmd_en;
  // pages outside 0 to 11 and 255 do not support the command and also fault
  wire       op_valid  = (page_one || page_all) && (is_std || is_grp);
  wire       op_take   = op_wr && op_valid;
  wire       op_bad    = op_wr && !op_valid;
  wire       op_is_on  = op_std[`SOOC_OP_ON_BIT];
  wire       op_is_imm = (op_std == `SOOC_OP_OFF);
  wire       op_is_sft = (op_std == `SOOC_OP_SOFT);

  sooc_pkg::sooc_margin_t op_margin;

  // lower code of a level ignores faults, higher code acts on them
  assign op_margin = (CMD_DATA == `SOOC_OP_LOW_IGN)  ? sooc_pkg::SOOC_MRG_LOW_IGN :
                     (CMD_DATA == `SOOC_OP_LOW_ACT)  ? sooc_pkg::SOOC_MRG_LOW_ACT :
                     (CMD_DATA == `SOOC_OP_HIGH_IGN) ? sooc_pkg::SOOC_MRG_HIGH_IGN :
                     (CMD_DATA == `SOOC_OP_HIGH_ACT) ? sooc_pkg::SOOC_MRG_HIGH_ACT :
                     sooc_pkg::SOOC_MRG_OFF;

  // ----------------------------------------------------------------
  // shared supply conditions
  // ----------------------------------------------------------------
  // margining waits until no enabled channel is below power-good-on
  wire all_pg = &(PG_OK | ~CH_ENABLED);

  logic [`SOOC_NCH-1:0]   cmd_on_reg;
  logic [`SOOC_NCH-1:0]   cmd_imm_reg;
  logic [`SOOC_NCH-1:0]   hit;
  logic [`SOOC_NCH-1:0]   pin_on;
  logic [`SOOC_NCH-1:0]   src_on;
  logic [`SOOC_NCH-1:0]   off_imm;
  logic [`SOOC_NCH-1:0]   mrg_act;
  logic [`SOOC_NCH-1:0]   mrg_ign;
  logic [7:0]             op_rb_reg [0:`SOOC_NCH-1];
  sooc_pkg::sooc_margin_t margin_reg [0:`SOOC_NCH-1];

  // ----------------------------------------------------------------
  // per-channel state and source combination
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `SOOC_NCH; ch = ch + 1) begin : g_ch
      localparam logic [7:0] CH_PAGE = 8'(ch);
      wire grp_ok = (op_nib == `SOOC_NIB_GRP_A) ? !CH_IN_GROUP_B[ch] :
                    (op_nib == `SOOC_NIB_GRP_B) ?  CH_IN_GROUP_B[ch] : 1'b1;
      // a single page leaves every other supply alone
      assign hit[ch] = op_take && (page_all ? grp_ok : (CMD_PAGE == CH_PAGE));

      wire pin_lvl = CH_IN_GROUP_B[ch] ? SUPPLY_CTRL_PIN_B : SUPPLY_CTRL_PIN_A;
      assign pin_on[ch] = cfg.pin_pol ? pin_lvl : !pin_lvl;

      // with bit 4 clear only bias matters; a source with no enable contributes nothing
      assign src_on[ch] = !cfg.use_src ? BIAS_OK :
                          (cfg.cmd_en && cfg.pin_en) ?
                            (cfg.or_mode ? (cmd_on_reg[ch] || pin_on[ch])
                                         : (cmd_on_reg[ch] && pin_on[ch])) :
                          cfg.cmd_en ? cmd_on_reg[ch] :
                          cfg.pin_en ? pin_on[ch] : 1'b0;

      // a pin that holds the supply off decides how it turns off
      assign off_imm[ch] = !cfg.use_src ? 1'b1 :
                           (cfg.pin_en && !pin_on[ch]) ? cfg.pin_imm : cmd_imm_reg[ch];

      // margin only on an enabled supply that is on, once all enabled rails are good
      assign mrg_act[ch] = CH_ENABLED[ch] && SUPPLY_ON[ch] && all_pg &&
                           (margin_reg[ch] != sooc_pkg::SOOC_MRG_OFF);
      assign mrg_ign[ch] = (margin_reg[ch] == sooc_pkg::SOOC_MRG_LOW_IGN) ||
                           (margin_reg[ch] == sooc_pkg::SOOC_MRG_HIGH_IGN);

      // state changes only on a taken command, so it persists otherwise
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          cmd_on_reg[ch]  <= 1'b0;
          cmd_imm_reg[ch] <= 1'b0;
        end else if (hit[ch] && cfg.cmd_en) begin
          cmd_on_reg[ch]  <= op_is_on;
          cmd_imm_reg[ch] <= op_is_imm;
        end
      end

      // the margin part is decoded whether or not the command source is enabled
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          margin_reg[ch] <= sooc_pkg::SOOC_MRG_OFF;
        end else if (hit[ch] && op_is_on) begin
          margin_reg[ch] <= op_margin;
        end
      end

      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          op_rb_reg[ch] <= `SOOC_OP_RST;
        end else if (hit[ch]) begin
          op_rb_reg[ch] <= op_std;
        end
      end

      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          SUPPLY_ON[ch]     <= 1'b0;
          OFF_IMMEDIATE[ch] <= 1'b0;
          MARGIN_HIGH[ch]   <= 1'b0;
          MARGIN_LOW[ch]    <= 1'b0;
          FAULT_OUT[ch]     <= 1'b0;
        end else begin
          SUPPLY_ON[ch]     <= src_on[ch];
          OFF_IMMEDIATE[ch] <= off_imm[ch];
          MARGIN_HIGH[ch]   <= mrg_act[ch] && ((margin_reg[ch] == sooc_pkg::SOOC_MRG_HIGH_IGN) ||
                                               (margin_reg[ch] == sooc_pkg::SOOC_MRG_HIGH_ACT));
          MARGIN_LOW[ch]    <= mrg_act[ch] && ((margin_reg[ch] == sooc_pkg::SOOC_MRG_LOW_IGN) ||
                                               (margin_reg[ch] == sooc_pkg::SOOC_MRG_LOW_ACT));
          FAULT_OUT[ch]     <= FAULT_IN[ch] && !(mrg_act[ch] && mrg_ign[ch]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // fault flag and read-back
  // ----------------------------------------------------------------
  // page 255 reads back what channel 0 last took; a broadcast writes it too unless its group code leaves channel 0 out
  wire [7:0] rd_oper = page_one ? op_rb_reg[CMD_PAGE[3:0]] :
                       page_all ? op_rb_reg[0] : `SOOC_RD_ZERO;
  wire [7:0] rd_mux  = (CMD_CODE == `SOOC_CODE_OPER) ? rd_oper :
                       (CMD_CODE == `SOOC_CODE_CFG)  ? (cfg_reg & `SOOC_CFG_WMASK) : `SOOC_RD_ZERO;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      CML_FAULT <= 1'b0;
      RD_VALID  <= 1'b0;
      RD_DATA   <= `SOOC_RD_ZERO;
    end else begin
      CML_FAULT <= op_bad;
      RD_VALID  <= CMD_RD;
      RD_DATA   <= CMD_RD ? rd_mux : RD_DATA;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  wire cmd_only = cfg.use_src && cfg.cmd_en && !cfg.pin_en;
  wire both_and = cfg.use_src && cfg.cmd_en && cfg.pin_en && !cfg.or_mode;
  wire both_or  = cfg.use_src && cfg.cmd_en && cfg.pin_en && cfg.or_mode;
  wire pin_only = cfg.use_src && !cfg.cmd_en && cfg.pin_en;
  wire no_src   = cfg.use_src && !cfg.cmd_en && !cfg.pin_en;
  wire ign_code = (CMD_DATA == `SOOC_OP_LOW_IGN) || (CMD_DATA == `SOOC_OP_HIGH_IGN);
  wire act_code = (CMD_DATA == `SOOC_OP_LOW_ACT) || (CMD_DATA == `SOOC_OP_HIGH_ACT);

  sequence s_take0(logic [7:0] code);
    op_take && hit[0] && (CMD_DATA == code) && cmd_only && !cfg_wr;
  endsequence

  sequence s_quiet;
    !op_wr && !cfg_wr && cmd_only;
  endsequence

  a_imm_off: assert property (s_take0(`SOOC_OP_OFF) ##1 s_quiet |=> !SUPPLY_ON[0] && OFF_IMMEDIATE[0])
    else $error("immediate off not applied");
  a_soft_off: assert property (s_take0(`SOOC_OP_SOFT) ##1 s_quiet |=> !SUPPLY_ON[0] && !OFF_IMMEDIATE[0])
    else $error("soft off not applied");
  a_bad_byte: assert property (op_bad |=> CML_FAULT)
    else $error("invalid byte raised no fault");
  a_bad_hold: assert property (op_bad && !cfg_wr |=> $stable(cmd_on_reg) && $stable(cmd_imm_reg))
    else $error("invalid byte changed state");
  a_act_pass: assert property (mrg_act[0] && !mrg_ign[0] && FAULT_IN[0] |=> FAULT_OUT[0])
    else $error("act-on-fault margin dropped a fault");
  a_ign_mask: assert property (mrg_act[0] && mrg_ign[0] |=> !FAULT_OUT[0])
    else $error("ignore-faults margin passed a fault");
  a_pg_gate: assert property (!all_pg |=> (MARGIN_HIGH == '0) && (MARGIN_LOW == '0))
    else $error("margin began before power good");
  a_and_off: assert property (both_and && !pin_on[0] |=> !SUPPLY_ON[0])
    else $error("and mode pin off did not turn off");
  a_bias_on: assert property (!cfg.use_src && BIAS_OK |=> SUPPLY_ON == {`SOOC_NCH{1'b1}})
    else $error("bias did not turn supplies on");
  a_rb_std: assert property (hit[0] |=> (op_rb_reg[0] == $past(op_std)) && (op_rb_reg[0][1:0] == 2'b00))
    else $error("read-back holds a special code");

  // ----------------------------------------------------------------
  // checks: addressing and persistence
  // ----------------------------------------------------------------
  // only a taken command may move what a supply remembers
  a_state_hold: assert property (!hit[0] |=> $stable(cmd_on_reg[0]) && $stable(margin_reg[0]))
    else $error("supply state moved without a command");

  a_page_one: assert property (op_take && page_one |-> $onehot(hit))
    else $error("single page reached another supply");

  a_page_all: assert property (op_take && page_all && std_mrg |-> (&hit))
    else $error("broadcast margin missed a supply");

  a_grp_both: assert property (op_take && page_all && (op_nib == `SOOC_NIB_BOTH) |-> (&hit))
    else $error("both-group code missed a supply");

  a_grp_a: assert property (op_take && page_all && (op_nib == `SOOC_NIB_GRP_A) |-> hit == ~CH_IN_GROUP_B)
    else $error("group a code hit the wrong supplies");

  a_grp_b: assert property (op_take && page_all && (op_nib == `SOOC_NIB_GRP_B) |-> hit == CH_IN_GROUP_B)
    else $error("group b code hit the wrong supplies");

  a_grp_gated: assert property (op_wr && grp_base && grp_nib && !cfg.cmd_en |-> op_bad)
    else $error("group code taken with command source off");

  // ----------------------------------------------------------------
  // checks: byte decode
  // ----------------------------------------------------------------
  sequence s_hit0_en;
    hit[0] && cfg.cmd_en;
  endsequence

  a_on_codes: assert property (s_hit0_en ##0 (std_on || std_mrg) |=> cmd_on_reg[0])
    else $error("on code left the command off");

  a_off_codes: assert property (s_hit0_en ##0 (std_off || std_soft) |=> !cmd_on_reg[0])
    else $error("off code left the command on");

  a_cmd_gated: assert property (op_take && !cfg.cmd_en |=> $stable(cmd_on_reg) && $stable(cmd_imm_reg))
    else $error("disabled command source moved on/off state");

  a_mrg_high: assert property (hit[0] && (CMD_DATA == `SOOC_OP_HIGH_ACT)
                               |=> margin_reg[0] == sooc_pkg::SOOC_MRG_HIGH_ACT)
    else $error("margin high code not stored");

  a_mrg_low: assert property (hit[0] && (CMD_DATA == `SOOC_OP_LOW_IGN)
                              |=> margin_reg[0] == sooc_pkg::SOOC_MRG_LOW_IGN)
    else $error("margin low code not stored");

  a_ign_codes: assert property (hit[0] && ign_code |=> mrg_ign[0])
    else $error("lower margin code does not ignore faults");

  a_act_codes: assert property (hit[0] && act_code |=> !mrg_ign[0] && (margin_reg[0] != sooc_pkg::SOOC_MRG_OFF))
    else $error("higher margin code does not act on faults");

  a_off_keeps: assert property (hit[0] && !op_is_on |=> $stable(margin_reg[0]))
    else $error("off code changed the margin mode");

  // ----------------------------------------------------------------
  // checks: source combination
  // ----------------------------------------------------------------
  // channel 0 sits in group a, so pin a is the one that drives it
  a_or_cmd: assert property (both_or && cmd_on_reg[0] |=> SUPPLY_ON[0])
    else $error("or mode command on did not turn on");

  a_and_on: assert property (both_and && cmd_on_reg[0] && pin_on[0] |=> SUPPLY_ON[0])
    else $error("and mode with both on did not turn on");

  a_and_cmd: assert property (both_and && !cmd_on_reg[0] |=> !SUPPLY_ON[0])
    else $error("and mode command off did not turn off");

  a_no_src: assert property (no_src |=> SUPPLY_ON == '0)
    else $error("supply on with no source enabled");

  a_cmd_src: assert property (cmd_only |=> SUPPLY_ON == $past(cmd_on_reg))
    else $error("command-only mode does not follow the command");

  a_pin_low: assert property (pin_only && !cfg.pin_pol && !SUPPLY_CTRL_PIN_A && !CH_IN_GROUP_B[0] |=> SUPPLY_ON[0])
    else $error("active-low pin did not turn on");

  a_pin_imm: assert property (cfg.use_src && cfg.pin_en && !pin_on[0] |=> OFF_IMMEDIATE[0] == $past(cfg.pin_imm))
    else $error("pin turn-off action not applied");

  a_pins_alike: assert property (pin_only && (SUPPLY_CTRL_PIN_A == SUPPLY_CTRL_PIN_B)
                                 |=> SUPPLY_ON == {`SOOC_NCH{SUPPLY_ON[0]}})
    else $error("control pins treated differently");

  a_bias_off: assert property (!cfg.use_src && !BIAS_OK |=> SUPPLY_ON == '0)
    else $error("supply on without bias");

  // ----------------------------------------------------------------
  // checks: flags and margin outputs
  // ----------------------------------------------------------------
  a_good_quiet: assert property (!op_bad |=> !CML_FAULT)
    else $error("fault flag raised without an invalid byte");

  a_rd_pulse: assert property (CMD_RD |=> RD_VALID)
    else $error("read not answered in the next cycle");

  a_mrg_on: assert property (CH_ENABLED[0] && SUPPLY_ON[0] && all_pg &&
                             (margin_reg[0] == sooc_pkg::SOOC_MRG_HIGH_ACT) |=> MARGIN_HIGH[0])
    else $error("margin high not requested when allowed");

  a_mrg_disabled: assert property (!CH_ENABLED[0] |=> !MARGIN_HIGH[0] && !MARGIN_LOW[0])
    else $error("margin requested on a disabled supply");

endmodule : sooc_top

// File: verif/sooc_host.sv
// Host model: one command byte per request, strobe held for one cycle.
// Assumes the bench calls xfer from a single process.
`timescale 1ns/1ps

module sooc_host (
  input  wire logic       clk,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      code,
  output logic [7:0]      data,
  output logic [7:0]      page,
  input  wire logic       cml,
  input  wire logic       rvalid,
  input  wire logic [7:0] rdata
);
  int gap = 0;

  initial {wr, rd, code, data, page} = '0;

  // released fields show the inverse, so a stale byte is never taken for a valid one
  task automatic xfer(input logic w, input logic [7:0] c, d, p, output logic [7:0] r, output logic f);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    {wr, rd, code, data, page} = {w, ~w, c, d, p};
    @(posedge clk);
    #1;
    r = rdata;
    f = w ? cml : rvalid;
    {wr, rd, code, data, page} = {2'b00, ~c, ~d, ~p};
  endtask : xfer

endmodule : sooc_host

// File: verif/sooc_top_tb.sv
// Self-checking bench of the on/off and margin command decoder.
// Assumes sooc_host drives the command strobes; pins and monitors are driven here.
`timescale 1ns/1ps
`include "sooc_params.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; $display("unexpected %s expected %h seen %h", n, e, a); end end

module sooc_top_tb;
  localparam logic [11:0] GRPB = 12'hFC0;
  logic                clock = 1'b0;
  logic                rst_n;
  logic                wr, rd, cml, rvalid, pin_a, pin_b, bias;
  logic [7:0]          code, data, page, rdata;
  logic [11:0]         ch_en, pg_ok, flt_in, s_on, off_im, m_hi, m_lo, flt_out;
  logic [11:0]         con, kim, known, mhi, mlo, mign;
  logic [7:0]          rb [12];
  sooc_pkg::sooc_cfg_t cfg;
  int                  fails = 0, checks = 0, cyc = 0;
  logic [31:0]         seed = 32'h000138F1;
  logic [7:0]          codes [14] = '{8'h00, 8'h01, 8'h02, 8'h40, 8'h41, 8'h42, 8'h80, 8'h81, 8'h82,
                                      8'h94, 8'h98, 8'hA4, 8'hA8, 8'h13};

  always #2 clock = ~clock;

  sooc_host sooc_host_i (.clk(clock), .wr(wr), .rd(rd), .code(code), .data(data), .page(page),
                         .cml(cml), .rvalid(rvalid), .rdata(rdata));

  sooc_top sooc_top_i (.CLOCK(clock), .RST_N(rst_n), .CMD_WR(wr), .CMD_RD(rd), .CMD_CODE(code),
    .CMD_DATA(data), .CMD_PAGE(page), .RD_DATA(rdata), .RD_VALID(rvalid), .CML_FAULT(cml),
    .SUPPLY_CTRL_PIN_A(pin_a), .SUPPLY_CTRL_PIN_B(pin_b), .BIAS_OK(bias), .CH_ENABLED(ch_en),
    .CH_IN_GROUP_B(GRPB), .PG_OK(pg_ok), .FAULT_IN(flt_in), .SUPPLY_ON(s_on),
    .OFF_IMMEDIATE(off_im), .MARGIN_HIGH(m_hi), .MARGIN_LOW(m_lo), .FAULT_OUT(flt_out));

  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h80200003 : seed >> 1;
    return seed;
  endfunction : rnd

  function automatic logic pin_on(int i);
    return (GRPB[i] ? pin_b : pin_a) == cfg.pin_pol;
  endfunction : pin_on

  function automatic logic exp_on(int i);
    if (!cfg.use_src) return bias;
    if (cfg.cmd_en && cfg.pin_en) return cfg.or_mode ? con[i] | pin_on(i) : con[i] & pin_on(i);
    return cfg.cmd_en & con[i] | cfg.pin_en & pin_on(i);
  endfunction : exp_on

  // returns the expected fault flag; a refused byte leaves the model untouched
  function automatic logic apply(input logic [7:0] d, p);
    logic ok;
    ok = d inside {8'h00, 8'h40, 8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8} ||
         d inside {8'h01, 8'h02, 8'h41, 8'h42, 8'h81, 8'h82} && p == 8'hFF && cfg.cmd_en;
    if (!ok || p > 8'h0B && p != 8'hFF) return 1'b1;
    for (int i = 0; i < 12; i++) begin
      if (p == 8'hFF ? d[1:0] == 2'b00 || d[1:0] == {GRPB[i], ~GRPB[i]} : p == i) begin
        rb[i] = d & 8'hFC;
        // any enabled command, on codes too, records whether it was an immediate off
        if (cfg.cmd_en) {con[i], kim[i], known[i]} = {d[7], ~d[7] & ~d[6], 1'b1};
        if (d[7]) {mhi[i], mlo[i], mign[i]} = {d[5], d[4], d[2]};
      end
    end
    return 1'b0;
  endfunction : apply

  task automatic check_all();
    logic [11:0] on, im, msk, hi, lo, fo;
    logic        act, pin_off;
    for (int i = 0; i < 12; i++) begin
      on[i] = exp_on(i);
      pin_off = cfg.pin_en & !pin_on(i);
      act = ch_en[i] & on[i] & &(pg_ok | ~ch_en);
      hi[i] = act & mhi[i];
      lo[i] = act & mlo[i];
      fo[i] = flt_in[i] & ~(act & (mhi[i] | mlo[i]) & mign[i]);
      im[i] = !cfg.use_src | pin_off ? !cfg.use_src | cfg.pin_imm : kim[i];
      msk[i] = ~on[i] & (!cfg.use_src | pin_off | known[i]);
    end
    `CHK("SUPPLY_ON", on, s_on)
    `CHK("OFF_IMMEDIATE", im & msk, off_im & msk)
    `CHK("MARGIN_HIGH", hi, m_hi)
    `CHK("MARGIN_LOW", lo, m_lo)
    `CHK("FAULT_OUT", fo, flt_out)
  endtask : check_all

  task automatic rd_chk(input logic [7:0] c, p, e);
    logic [7:0] r;
    logic       f;
    sooc_host_i.xfer(1'b0, c, 8'h00, p, r, f);
    `CHK("RD_VALID", 1'b1, f)
    `CHK("RD_DATA", e, r)
  endtask : rd_chk

  task automatic op(input logic [7:0] c, d, p);
    logic [7:0] r;
    logic       f, ef;
    ef = 1'b0;
    if (c == 8'h02) cfg = d & 8'h3F;
    else ef = apply(d, p);
    sooc_host_i.xfer(1'b1, c, d, p, r, f);
    `CHK("CML_FAULT", ef, f)
    repeat (2) @(posedge clock);
    #1;
    check_all();
    rd_chk(8'h01, p, p == 8'hFF ? rb[0] : p < 8'h0C ? rb[p[3:0]] : 8'h00);
    rd_chk(8'h02, 8'hFF, cfg);
  endtask : op

  // reset the design and the model together, then check the reset state
  task automatic reset_dut();
    rst_n = 1'b0;
    cfg = 8'h1E;
    {con, kim, known, mhi, mlo, mign} = '0;
    foreach (rb[i]) rb[i] = 8'h00;
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check_all();
    rd_chk(8'h01, 8'hFF, 8'h00);
    rd_chk(8'h02, 8'hFF, 8'h1E);
  endtask : reset_dut

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // cut a hang short well beyond the few thousand cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    logic [31:0] r;
    {pin_a, pin_b, bias, ch_en, pg_ok, flt_in} = {3'b111, 12'hFFF, 12'hFFF, 12'h000};
    reset_dut();
    $display("test reset done");
    for (int k = 0; k < 14; k++) op(8'h01, codes[k], 8'hFF);
    for (int k = 0; k < 14; k++) op(8'h01, codes[k], 8'h03);
    op(8'h02, 8'h18, 8'hFF);
    for (int k = 0; k < 14; k++) op(8'h01, codes[k], 8'h00);
    op(8'h02, 8'h16, 8'hFF);
    for (int k = 0; k < 14; k++) op(8'h01, codes[k], 8'hFF);
    $display("test directed done");
    reset_dut();
    $display("test mid reset done");
    for (int n = 0; n < 300; n++) begin
      r = rnd();
      {pin_a, pin_b, flt_in} = r[31:18];
      bias = r[17] | r[16] | cfg.use_src | (r[13:11] == 3'h0);
      ch_en = r[15] ? 12'hFFF : 12'hDFF;
      pg_ok = r[14] ? 12'hFFF : 12'hFEF;
      sooc_host_i.gap = r[1:0];
      if (r[13:11] == 3'h0) op(8'h02, r[7:0], 8'hFF);
      else op(8'h01, r[12] ? codes[r[10:8] + r[6:4] % 7] : r[7:0],
              r[5:4] == 2'h3 ? 8'hFF : r[3:0] < 4'hC ? {4'h0, r[3:0]} : 8'h2A);
    end
    $display("test random done");
    stop_test();
  end

endmodule : sooc_top_tb
